/* verilog/pcb_defs.svh */
`ifndef PCB_DEFS_SVH
`define PCB_DEFS_SVH
// Operation
// RQ1: Batch counts preset completions, kept separately.
// RQ2: Batch reset holds batch count at zero.
// RQ3: Batch set zero: count, never batch output.
// RQ4: Batch count wraps to zero at maximum.
// RQ5: Batch output restored after power returns.
// RQ6: Lowering batch set below count sets output.
// RQ7: Batch output latched; only batch reset clears.
// RQ8: Dual output on when result matches set.
// RQ9: Dual mode drives both outputs together.
// RQ10: First reset stops first channel, counts zero.
// RQ11: Second reset stops second channel, counts zero.
// RQ12: Dual result is signed within documented range.
// RQ13: Channel values unsigned, zero to maximum.
// RQ14: Channel overflow flags and stops all counting.
// RQ15: Main reset clears present value and output.
// RQ16: Second reset clears total only; else nothing.
// RQ17: Batch mode second reset clears batch state.
// RQ18: Dual first reset clears first channel only.
// RQ19: Tachometer output: four selectable comparison modes.
// RQ20: First input speed 30 Hz filtered or 10 kHz.
// RQ21: Measurement is frequency times prescale value.
// RQ22: Decimal point applied to measurement and sets.
// RQ23: Switch settings sampled only at power on.
// RQ24: Completion when present value reaches set value.
// RQ25: Dual mode adds, or subtracts second from first.
// RQ26: Pulses synchronised, edge detected, one count each.

// Clock and timing.
`define PCB_CLK_HZ        40000000
`define PCB_MS_PER_S      1000
`define PCB_SPEED_SLOW_HZ 30
`define PCB_SPEED_FAST_HZ 10000
`define PCB_FILT_SLOW_CYC (`PCB_CLK_HZ / (2 * `PCB_SPEED_SLOW_HZ))
`define PCB_FILT_FAST_CYC (`PCB_CLK_HZ / (2 * `PCB_SPEED_FAST_HZ))
`define PCB_GATE_MS       1000
`define PCB_GATE_CYC      (`PCB_CLK_HZ / `PCB_MS_PER_S * `PCB_GATE_MS)

// Count ranges and scaling.
`define PCB_MAX6          20'd999999
`define PCB_MAX4          20'd9999
`define PCB_MIN6          (-22'sd99999)
`define PCB_MIN4          (-22'sd999)
`define PCB_PRESCALE_DEN  50'd10000
`define PCB_ZERO_CNT      20'h00000
`endif

/* verilog/pcb_pkg.sv */
package pcb_pkg;
  // Counter function, Gray coded along the configuration order.
  typedef enum logic [2:0] {
    PCB_SINGLE = 3'h0,
    PCB_TWO    = 3'h1,
    PCB_TOTAL  = 3'h3,
    PCB_BATCH  = 3'h2,
    PCB_DUAL   = 3'h6,
    PCB_TACHO  = 3'h7
  } pcb_mode_t;

  typedef enum logic [1:0] {
    PCB_BAND_LIMITS_MODE = 2'h0,
    PCB_AREA_MODE        = 2'h1,
    PCB_DUAL_UPPER_MODE  = 2'h3,
    PCB_DUAL_LOWER_MODE  = 2'h2
  } pcb_tach_t;

  typedef enum logic [1:0] {
    PCB_CFG_S0  = 2'h0,
    PCB_CFG_S1  = 2'h1,
    PCB_CFG_S2  = 2'h3,
    PCB_CFG_RUN = 2'h2
  } pcb_cfg_state_t;

  // Switch settings, sampled once after power on.
  typedef struct packed {
    pcb_mode_t mode;
    pcb_tach_t tach_mode;
    logic      slow_speed;
    logic      four_digit;
    logic      dual_sub;
  } pcb_dip_t;

  // Set values from the key panel logic on the same clock.
  typedef struct packed {
    logic [19:0]        set_value1;
    logic [19:0]        set_value2;
    logic [19:0]        batch_set;
    logic signed [20:0] dual_set;
    logic [19:0]        prescale;
    logic [1:0]         decimal_point_position;
  } pcb_setp_t;

  typedef struct packed {
    logic [19:0]        present_a;
    logic [19:0]        present_b;
    logic [19:0]        total_count;
    logic [19:0]        batch_count;
    logic signed [20:0] dual_value;
    logic [19:0]        measurement;
    logic               overflow;
    logic               batch_out_retain;
    logic [1:0]         decimal_point_position;
  } pcb_status_t;
endpackage

/* verilog/pcb_core.sv */
`timescale 1ns/100ps
`include "pcb_defs.svh"
module pcb_core #(
  parameter int unsigned GATE_CYC      = `PCB_GATE_CYC,
  parameter int unsigned FILT_SLOW_CYC = `PCB_FILT_SLOW_CYC
) (
  input  wire logic               core_clk,
  input  wire logic               srst,
  input  wire logic               ce,
  input  wire logic               count_pulse_a,
  input  wire logic               count_pulse_b,
  input  wire logic               reset_first,
  input  wire logic               reset_second,
  input  wire logic               batch_out_saved,
  input  wire pcb_pkg::pcb_dip_t  dip,
  input  wire pcb_pkg::pcb_setp_t setp,
  output logic                    control_output_first,
  output logic                    control_output_second,
  output pcb_pkg::pcb_status_t    status
);

  localparam logic [19:0] FILT_FAST = 20'(`PCB_FILT_FAST_CYC);
  localparam logic [19:0] FILT_SLOW = 20'(FILT_SLOW_CYC);
  localparam logic [25:0] GATE_LAST = 26'(GATE_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [12:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic        pa_s, pb_s, rst1_s, rst2_s, restore_s;
  pcb_pkg::pcb_dip_t dip_s;

  // Every pin passes two flip-flops before any logic reads it.
  always_comb begin
    sync1_d = {count_pulse_a, count_pulse_b, reset_first, reset_second, batch_out_saved, dip};
    sync2_d = sync1_q;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_q <= 13'h0000;
      sync2_q <= 13'h0000;
    end else if (ce) begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  assign pa_s      = sync2_q[12];
  assign pb_s      = sync2_q[11];
  assign rst1_s    = sync2_q[10];
  assign rst2_s    = sync2_q[9];
  assign restore_s = sync2_q[8];
  assign dip_s     = pcb_pkg::pcb_dip_t'(sync2_q[7:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Input filter and edge detection.

  pcb_pkg::pcb_dip_t cfg_q, cfg_d;
  logic [19:0] flt_cnt_q, flt_cnt_d, flt_lim;
  logic        flt_q, flt_d, flt_old_q, b_old_q, pulse_a, pulse_b;

  // The slow setting rejects contact chatter: a level must stand for half a
  // period of the top rate before it is believed; this also caps the rate.
  always_comb begin
    flt_lim   = cfg_q.slow_speed ? FILT_SLOW : FILT_FAST; // RQ20
    flt_d     = flt_q;
    flt_cnt_d = 20'h00000;
    if (pa_s != flt_q) begin
      if (20'(flt_cnt_q + 20'h00001) >= flt_lim) begin
        flt_d = pa_s; // RQ20
      end else begin
        flt_cnt_d = 20'(flt_cnt_q + 20'h00001);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      flt_q     <= 1'b0;
      flt_cnt_q <= 20'h00000;
      flt_old_q <= 1'b0;
      b_old_q   <= 1'b0;
    end else if (ce) begin
      flt_q     <= flt_d;
      flt_cnt_q <= flt_cnt_d;
      flt_old_q <= flt_q;
      b_old_q   <= pb_s;
    end
  end

  // One rising edge gives exactly one count enable.
  assign pulse_a = flt_q & ~flt_old_q; // RQ26
  assign pulse_b = pb_s & ~b_old_q; // RQ26

  ////////////////////////////////////////////////////////////////////////////
  // Counting core.

  pcb_pkg::pcb_cfg_state_t cfg_state_q, cfg_state_d;
  logic [19:0]        pv_a_q, pv_a_d, pv_b_q, pv_b_d, total_q, total_d;
  logic [19:0]        batch_q, batch_d, meas_q, meas_d, freq_q, freq_d;
  logic [25:0]        gate_q, gate_d;
  logic signed [20:0] dual_q, dual_d;
  logic               batch_out_q, batch_out_d, control_output_first_q, control_output_first_d, control_output_second_q, control_output_second_d;
  logic               ovf_a_q, ovf_a_d, ovf_b_q, ovf_b_d, dual_ovf_q, dual_ovf_d;
  logic [1:0]         dp_q;
  logic               done, stop;
  logic [19:0]        maxv;
  logic signed [21:0] minv, sum;
  logic [49:0]        prod;
  logic [9:0]         pow10;

  assign stop = ovf_a_q | ovf_b_q | dual_ovf_q;

  // Next state of all counters and outputs; a mode code that is not one of
  // the six functions leaves everything frozen with outputs off.
  always_comb begin
    cfg_state_d = cfg_state_q;
    cfg_d       = cfg_q;
    pv_a_d      = pv_a_q;
    pv_b_d      = pv_b_q;
    total_d     = total_q;
    batch_d     = batch_q;
    batch_out_d = batch_out_q;
    control_output_first_d      = control_output_first_q;
    control_output_second_d      = control_output_second_q;
    ovf_a_d     = ovf_a_q;
    ovf_b_d     = ovf_b_q;
    dual_d      = dual_q;
    dual_ovf_d  = dual_ovf_q;
    gate_d      = gate_q;
    freq_d      = freq_q;
    meas_d      = meas_q;
    done        = 1'b0;
    sum         = 22'sh000000;
    prod        = 50'h0;
    maxv        = cfg_q.four_digit ? `PCB_MAX4 : `PCB_MAX6;
    minv        = cfg_q.four_digit ? `PCB_MIN4 : `PCB_MIN6;
    case (setp.decimal_point_position)
      2'h0:    pow10 = 10'd1;
      2'h1:    pow10 = 10'd10;
      2'h2:    pow10 = 10'd100;
      default: pow10 = 10'd1000;
    endcase

    // The synchronisers need two edges to fill, so switches are taken on the
    // third; later changes are never looked at again.
    unique case (cfg_state_q)
      pcb_pkg::PCB_CFG_S0: cfg_state_d = pcb_pkg::PCB_CFG_S1;
      pcb_pkg::PCB_CFG_S1: cfg_state_d = pcb_pkg::PCB_CFG_S2;
      pcb_pkg::PCB_CFG_S2: begin
        cfg_d       = dip_s; // RQ23
        batch_out_d = restore_s; // RQ5
        cfg_state_d = pcb_pkg::PCB_CFG_RUN;
      end
      pcb_pkg::PCB_CFG_RUN: ;
    endcase

    if (cfg_state_q == pcb_pkg::PCB_CFG_RUN) begin
      unique case (cfg_q.mode)
        pcb_pkg::PCB_SINGLE, pcb_pkg::PCB_TWO, pcb_pkg::PCB_TOTAL, pcb_pkg::PCB_BATCH: begin
          if (rst1_s) begin
            pv_a_d = `PCB_ZERO_CNT; // RQ15
            control_output_first_d = 1'b0;
            control_output_second_d = 1'b0;
          end else if (pulse_a) begin
            pv_a_d = (pv_a_q == maxv) ? `PCB_ZERO_CNT : 20'(pv_a_q + 20'h00001);
            done   = (pv_a_d == setp.set_value1); // RQ24
            if (cfg_q.mode == pcb_pkg::PCB_TWO) begin
              if (pv_a_d == setp.set_value1) control_output_first_d = 1'b1;
              if (pv_a_d == setp.set_value2) control_output_second_d = 1'b1;
            end else if (done) begin
              control_output_first_d = 1'b1;
              control_output_second_d = 1'b1;
            end
          end
          // Total count follows every accepted pulse.
          if (cfg_q.mode == pcb_pkg::PCB_TOTAL) begin
            if (rst2_s) begin
              total_d = `PCB_ZERO_CNT; // RQ16
            end else if (pulse_a && !rst1_s) begin
              total_d = (total_q == maxv) ? `PCB_ZERO_CNT : 20'(total_q + 20'h00001);
            end
          end
          // Batch mode restarts the preset count at each completion.
          if (cfg_q.mode == pcb_pkg::PCB_BATCH) begin
            if (done) pv_a_d = `PCB_ZERO_CNT;
            if (rst2_s) begin
              batch_d     = `PCB_ZERO_CNT; // RQ2
              batch_out_d = 1'b0; // RQ17
            end else begin
              if (done) batch_d = (batch_q == maxv) ? `PCB_ZERO_CNT : 20'(batch_q + 20'h00001); // RQ1 RQ4
              // A level compare catches both counting up and the set value
              // being lowered; nothing but the reset clears the latch.
              if (setp.batch_set != `PCB_ZERO_CNT && batch_d >= setp.batch_set) begin
                batch_out_d = 1'b1; // RQ3 RQ6 RQ7
              end
            end
            control_output_first_d = batch_out_d;
          end
        end
        pcb_pkg::PCB_DUAL: begin
          if (rst1_s) begin
            pv_a_d  = `PCB_ZERO_CNT; // RQ10 RQ18
            ovf_a_d = 1'b0;
          end else if (pulse_a && !stop) begin
            if (pv_a_q == maxv) ovf_a_d = 1'b1; // RQ13 RQ14
            else pv_a_d = 20'(pv_a_q + 20'h00001);
          end
          if (rst2_s) begin
            pv_b_d  = `PCB_ZERO_CNT; // RQ11
            ovf_b_d = 1'b0;
          end else if (pulse_b && !stop) begin
            if (pv_b_q == maxv) ovf_b_d = 1'b1; // RQ13 RQ14
            else pv_b_d = 20'(pv_b_q + 20'h00001);
          end
          if (cfg_q.dual_sub) sum = $signed({2'b00, pv_a_d}) - $signed({2'b00, pv_b_d}); // RQ25
          else sum = $signed({2'b00, pv_a_d}) + $signed({2'b00, pv_b_d});
          dual_ovf_d = (sum > $signed({2'b00, maxv})) || (sum < minv); // RQ12 RQ14
          if (!dual_ovf_d) dual_d = 21'(sum);
          control_output_first_d = (sum == 22'(setp.dual_set)); // RQ8
          control_output_second_d = control_output_first_d; // RQ9
        end
        pcb_pkg::PCB_TACHO: begin
          // One gate of a second counts pulses; the count is hertz.
          if (gate_q == GATE_LAST) begin
            gate_d = 26'h0000000;
            freq_d = {19'h00000, pulse_a};
            prod   = 50'(freq_q) * 50'(setp.prescale) * 50'(pow10); // RQ21 RQ22
            prod   = prod / `PCB_PRESCALE_DEN;
            meas_d = (prod > 50'(maxv)) ? maxv : prod[19:0];
          end else begin
            gate_d = 26'(gate_q + 26'h0000001);
            if (pulse_a) freq_d = 20'(freq_q + 20'h00001);
          end
          unique case (cfg_q.tach_mode)
            pcb_pkg::PCB_BAND_LIMITS_MODE: begin
              control_output_first_d = meas_q >= setp.set_value1; // RQ19
              control_output_second_d = meas_q <= setp.set_value2;
            end
            pcb_pkg::PCB_AREA_MODE: begin
              control_output_first_d = (meas_q <= setp.set_value1) && (meas_q >= setp.set_value2); // RQ19
              control_output_second_d = control_output_first_d;
            end
            pcb_pkg::PCB_DUAL_UPPER_MODE: begin
              control_output_first_d = meas_q >= setp.set_value1; // RQ19
              control_output_second_d = meas_q >= setp.set_value2;
            end
            pcb_pkg::PCB_DUAL_LOWER_MODE: begin
              control_output_first_d = meas_q <= setp.set_value1; // RQ19
              control_output_second_d = meas_q <= setp.set_value2;
            end
          endcase
        end
        default: begin
          control_output_first_d = 1'b0;
          control_output_second_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_state_q <= pcb_pkg::PCB_CFG_S0;
      cfg_q       <= pcb_pkg::pcb_dip_t'(8'h00);
      pv_a_q      <= `PCB_ZERO_CNT;
      pv_b_q      <= `PCB_ZERO_CNT;
      total_q     <= `PCB_ZERO_CNT;
      batch_q     <= `PCB_ZERO_CNT;
      batch_out_q <= 1'b0;
      control_output_first_q      <= 1'b0;
      control_output_second_q      <= 1'b0;
      ovf_a_q     <= 1'b0;
      ovf_b_q     <= 1'b0;
      dual_q      <= 21'sh000000;
      dual_ovf_q  <= 1'b0;
      gate_q      <= 26'h0000000;
      freq_q      <= `PCB_ZERO_CNT;
      meas_q      <= `PCB_ZERO_CNT;
      dp_q        <= 2'h0;
    end else if (ce) begin
      cfg_state_q <= cfg_state_d;
      cfg_q       <= cfg_d;
      pv_a_q      <= pv_a_d;
      pv_b_q      <= pv_b_d;
      total_q     <= total_d;
      batch_q     <= batch_d;
      batch_out_q <= batch_out_d;
      control_output_first_q      <= control_output_first_d;
      control_output_second_q      <= control_output_second_d;
      ovf_a_q     <= ovf_a_d;
      ovf_b_q     <= ovf_b_d;
      dual_q      <= dual_d;
      dual_ovf_q  <= dual_ovf_d;
      gate_q      <= gate_d;
      freq_q      <= freq_d;
      meas_q      <= meas_d;
      dp_q        <= setp.decimal_point_position;
    end
  end

  // All outputs come straight from flip-flops except status overflow, an OR of three flags.
  assign control_output_first  = control_output_first_q;
  assign control_output_second = control_output_second_q;
  assign status = '{present_a: pv_a_q, present_b: pv_b_q, total_count: total_q,
                    batch_count: batch_q, dual_value: dual_q, measurement: meas_q,
                    overflow: stop, batch_out_retain: batch_out_q, decimal_point_position: dp_q};

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  logic run, is_batch, is_dual;
  assign run      = cfg_state_q == pcb_pkg::PCB_CFG_RUN;
  assign is_batch = run && cfg_q.mode == pcb_pkg::PCB_BATCH;
  assign is_dual  = run && cfg_q.mode == pcb_pkg::PCB_DUAL;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_batch_reset_zero: // RQ2
    assert property (ce && is_batch && rst2_s |=> batch_q == 20'd0 && !batch_out_q)
      else $error("Batch count not held at zero during batch reset.");
  a_batch_zero_set: // RQ3
    assert property (run && ce && setp.batch_set == 20'd0 && !batch_out_q |=> !batch_out_q)
      else $error("Batch output rose with zero batch set value.");
  a_batch_wrap: // RQ4
    assert property (ce && is_batch && !rst2_s && done && batch_q == maxv |=> batch_q == 20'd0)
      else $error("Batch count did not wrap at maximum.");
  a_batch_lowered: // RQ6
    assert property (ce && is_batch && !rst2_s && setp.batch_set != 20'd0 && batch_q >= setp.batch_set
                     |=> batch_out_q && control_output_first)
      else $error("Batch output not set when set value below count.");
  a_batch_latched: // RQ7
    assert property (ce && is_batch && batch_out_q && !rst2_s |=> batch_out_q)
      else $error("Batch output dropped without batch reset.");
  a_dual_together: // RQ9
    assert property (is_dual ##1 is_dual |-> control_output_first == control_output_second)
      else $error("Dual outputs differ.");
  a_dual_match: // RQ8
    assert property (ce && is_dual && !dual_ovf_d && sum == 22'(setp.dual_set) |=> control_output_first_q && control_output_second_q)
      else $error("Dual output not on at matching result.");
  a_first_reset: // RQ10
    assert property (ce && is_dual && rst1_s |=> pv_a_q == 20'd0 && ($stable(pv_b_q) || $past(pulse_b || rst2_s)))
      else $error("First channel not cleared by first reset.");
  a_overflow_stop: // RQ14
    assert property (ce && is_dual && stop && !rst1_s && !rst2_s |=> $stable(pv_a_q) && $stable(pv_b_q))
      else $error("Counting continued after overflow.");
  a_main_reset: // RQ15
    assert property (ce && run && rst1_s && cfg_q.mode inside {pcb_pkg::PCB_SINGLE, pcb_pkg::PCB_TWO}
                     |=> pv_a_q == 20'd0 && !control_output_first_q && !control_output_second_q)
      else $error("Main reset did not clear value and output.");
  a_cfg_frozen: // RQ23
    assert property (run |=> $stable(cfg_q))
      else $error("Configuration changed after power on.");

  c_batch_out: cover property (is_batch && $rose(batch_out_q));
  c_dual_match: cover property (is_dual && $rose(control_output_first_q));
  c_overflow: cover property (is_dual && $rose(stop));
  c_tach_meas: cover property (run && cfg_q.mode == pcb_pkg::PCB_TACHO && $changed(meas_q));
endmodule

/* tb/pcb_pulse_src.sv */
`timescale 1ns/100ps
module pcb_pulse_src #(
  parameter int unsigned HOLD_CYC = 60
) (
  input  wire logic core_clk,
  output logic      count_pulse_a,
  output logic      count_pulse_b
);
  // Both pulse lines idle low, as an open sensor output pulled down would.
  initial begin
    count_pulse_a = 1'b0;
    count_pulse_b = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Each level is held longer than the slow filter, so every pulse qualifies once.
  task automatic pulses(input logic sel_b, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      if (sel_b) begin
        count_pulse_b = 1'b1;
      end else begin
        count_pulse_a = 1'b1;
      end
      repeat (HOLD_CYC) @(negedge core_clk);
      count_pulse_a = 1'b0;
      count_pulse_b = 1'b0;
      repeat (HOLD_CYC) @(negedge core_clk);
    end
  endtask

  // The second line has no filter, so a fast train of two cycles per level is enough.
  task automatic burst_b(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (2) @(negedge core_clk);
      count_pulse_b = 1'b1;
      repeat (2) @(negedge core_clk);
      count_pulse_b = 1'b0;
    end
  endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic                 core_clk;
  logic                 srst;
  logic                 ce;
  logic                 reset_first;
  logic                 reset_second;
  logic                 batch_out_saved;
  logic                 count_pulse_a;
  logic                 count_pulse_b;
  logic                 control_output_first;
  logic                 control_output_second;
  pcb_pkg::pcb_dip_t    dip;
  pcb_pkg::pcb_setp_t   setp;
  pcb_pkg::pcb_status_t status;
  int                   num_errors;
  int                   comparisons;
  int                   cycles;

  // Short gate and filter keep the run brief; the pulse model holds past the filter.
  // The gate spans exactly two pulse periods of 121 cycles, so each full gate sees two pulses.
  pcb_core #(.GATE_CYC(242), .FILT_SLOW_CYC(50)) u_dut (
    .core_clk              (core_clk),
    .srst                  (srst),
    .ce                    (ce),
    .count_pulse_a         (count_pulse_a),
    .count_pulse_b         (count_pulse_b),
    .reset_first           (reset_first),
    .reset_second          (reset_second),
    .batch_out_saved       (batch_out_saved),
    .dip                   (dip),
    .setp                  (setp),
    .control_output_first  (control_output_first),
    .control_output_second (control_output_second),
    .status                (status)
  );

  pcb_pulse_src #(.HOLD_CYC(60)) u_src (
    .core_clk      (core_clk),
    .count_pulse_a (count_pulse_a),
    .count_pulse_b (count_pulse_b)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 25 ns and a cycle ceiling well above the expected run length.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers for compares, waits and power-on resets.
  task automatic check(input logic [20:0] seen, input logic [20:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Switches are only captured after reset, so each test starts from power on.
  task automatic power_on(input pcb_pkg::pcb_mode_t m, input logic sub, input logic saved);
    @(negedge core_clk);
    dip = '{mode: m, tach_mode: dip.tach_mode, slow_speed: 1'b1,
            four_digit: 1'b1, dual_sub: sub};
    batch_out_saved = saved;
    srst = 1'b1;
    wait_cyc(8);
    srst = 1'b0;
    wait_cyc(8);
  endtask

  task automatic pulse_reset(input logic second);
    if (second) reset_second = 1'b1;
    else reset_first = 1'b1;
    wait_cyc(4);
    reset_first = 1'b0;
    reset_second = 1'b0;
    wait_cyc(4);
  endtask

  task automatic summarize();
    $display("counts: comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    reset_first = 1'b0;
    reset_second = 1'b0;
    batch_out_saved = 1'b0;
    dip = '0;
    setp = '0;
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    // Single, total and two-stage modes: completion, then the second reset.
    // The second set value lies beyond the count, so only the two-stage output 2 stays off.
    setp.set_value1 = 20'h00003;
    setp.set_value2 = 20'h00004;
    for (int k = 0; k < 3; k++) begin
      power_on(k == 0 ? pcb_pkg::PCB_SINGLE : (k == 1 ? pcb_pkg::PCB_TOTAL : pcb_pkg::PCB_TWO), 1'b0, 1'b0);
      u_src.pulses(1'b0, 3);
      check(control_output_first, 1, "control_output_first at set");
      check(control_output_second, k != 2, "control_output_second at set");
      pulse_reset(1'b1);
      check(status.present_a, 3, "pv after reset2");
      if (k == 1) check(status.total_count, 0, "total");
      else check(control_output_first, 1, "control_output_first kept");
      pulse_reset(1'b0);
      check(status.present_a, 0, "pv after reset1");
      check(control_output_second, 0, "out cleared");
      check(control_output_first, 0, "control_output_first cleared");
    end
    $display("test single_total done");
    // Batch mode; later switch changes must not matter.
    setp.set_value1 = 20'h00002;
    setp.batch_set = 20'h00002;
    power_on(pcb_pkg::PCB_BATCH, 1'b0, 1'b0);
    dip.mode = pcb_pkg::PCB_DUAL;
    u_src.pulses(1'b0, 4);
    check(status.batch_count, 2, "batch count");
    check(status.present_a, 0, "pv restarted");
    check(control_output_first, 1, "batch out");
    setp.batch_set = 20'h00005;
    wait_cyc(3);
    check(control_output_first, 1, "batch latched");
    reset_second = 1'b1;
    u_src.pulses(1'b0, 2);
    check(status.batch_count, 0, "held at zero");
    check(control_output_first, 0, "batch cleared");
    reset_second = 1'b0;
    u_src.pulses(1'b0, 4);
    check(control_output_first, 0, "below set");
    setp.batch_set = 20'h00001;
    wait_cyc(3);
    check(control_output_first, 1, "set lowered");
    pulse_reset(1'b1);
    setp.batch_set = 20'h00000;
    u_src.pulses(1'b0, 2);
    check(status.batch_count, 1, "zero set counts");
    check(control_output_first, 0, "zero set no out");
    power_on(pcb_pkg::PCB_BATCH, 1'b0, 1'b1);
    check(control_output_first, 1, "restored");
    check(status.batch_out_retain, 1, "retain");
    $display("test batch done");
    // Dual add, per-channel resets, then subtract.
    setp.dual_set = 21'sd5;
    power_on(pcb_pkg::PCB_DUAL, 1'b0, 1'b0);
    u_src.pulses(1'b0, 3);
    u_src.pulses(1'b1, 2);
    check(status.dual_value, 5, "dual add");
    check(control_output_first, 1, "dual match 1");
    check(control_output_second, 1, "dual match 2");
    // With the clock enable low the pin is never seen, so the second channel keeps its value.
    ce = 1'b0;
    u_src.pulses(1'b1, 1);
    ce = 1'b1;
    wait_cyc(4);
    check(status.present_b, 2, "frozen by ce");
    setp.dual_set = 21'sd4;
    wait_cyc(3);
    check(control_output_second, 0, "dual off");
    reset_first = 1'b1;
    u_src.pulses(1'b0, 1);
    check(status.present_a, 0, "a held");
    check(status.dual_value, 2, "a as zero");
    reset_first = 1'b0;
    reset_second = 1'b1;
    u_src.pulses(1'b0, 1);
    check(status.present_a, 1, "a unaffected");
    check(status.dual_value, 1, "b as zero");
    reset_second = 1'b0;
    setp.dual_set = -21'sd2;
    power_on(pcb_pkg::PCB_DUAL, 1'b1, 1'b0);
    u_src.pulses(1'b0, 1);
    u_src.pulses(1'b1, 3);
    check(status.dual_value, -21'sd2, "dual sub");
    check(control_output_first, 1, "negative match");
    // A long train on the second channel pushes the difference below the range.
    u_src.burst_b(1000);
    check(status.present_b, 1001, "b stopped");
    check(status.dual_value, -21'sd999, "dual held");
    check(status.overflow, 1, "overflow");
    $display("test dual done");
    // Tachometer: two pulses per gate, prescale 3.0 and one decimal place give 60, which
    // lies above set value 1 (50) and below set value 2 (70); the area band is then empty.
    setp.set_value1 = 20'h00032;
    setp.set_value2 = 20'h00046;
    setp.prescale = 20'h07530;
    setp.decimal_point_position = 2'h1;
    for (int t = 0; t < 4; t++) begin
      dip.tach_mode = pcb_pkg::pcb_tach_t'(t);
      power_on(pcb_pkg::PCB_TACHO, 1'b0, 1'b0);
      u_src.pulses(1'b0, 8);
      check(status.measurement, 60, "measurement");
      check(status.decimal_point_position, 1, "dp");
      check(control_output_first, t == 0 || t == 3, "tach control_output_first");
      check(control_output_second, t == 0 || t == 2, "tach control_output_second");
    end
    $display("test tacho done");
    summarize();
  end
endmodule
